// ==== verilog/ptbd_decoder.sv ====
// How it works
// [R1] One 64-bit word in, RGBA for all sixteen pixels out.
// [R2] Colour codes at 63-59, 55-51, 47-43 are unsigned 0..31.
// [R3] Delta codes at 58-56, 50-48, 42-40 are signed -4..+3.
// [R4] Red sum outside 0..31 selects T mode.
// [R5] Else green sum outside 0..31 selects H mode.
// [R6] Else blue sum outside 0..31 selects planar mode.
// [R7] All sums in range selects differential mode.
// [R8] Bit 32 clear: side-by-side halves; set: stacked halves.
// [R9] First base colour widens each code, copying top three bits below.
// [R10] Second base colour widens code plus delta the same way.
// [R11] Bits 39-37 and 36-34 are the two subblock table codes.
// [R12] Table code picks one of eight tables, set chosen by bit 33.
// [R13] Modifier tables are fixed constants inside the decoder.
// [R14] Magnitudes 2/8 through 47/183; small ones zero when bit 33 clear.
// [R15] Index MSB from upper half-word, LSB from lower half-word.
// [R16] Index bit positions do not depend on the partition bit.
// [R17] Bit 33 chooses between the two index mappings.
// [R18] 11 minus large, 01 plus large, 10/00 small or zero.
// [R19] Modifier is added to all three base channels.
// [R20] Each channel sum clamps to 0..255.
// [R21] Bit 33 clear and index 10, or a non-differential mode, gives all zero; else alpha 255.
// [R22] First memory byte is bits 63-56; mode is flagged for other handlers.
`timescale 1ns/10ps
module ptbd_decoder
  import ptbd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic word_valid_i,
  input wire logic [63:0] word_i,
  output logic ready_o,
  output logic texels_valid_o,
  output ptbd_mode_t mode_o,
  output logic diff_mode_o,
  output ptbd_texel_t [15:0] texels_o
);

  ptbd_mode_t sel_mode;
  ptbd_rgb_t first_base;
  ptbd_rgb_t second_base;
  ptbd_texel_t [15:0] calc;
  logic solid_alpha_flag;
  logic split_orientation_bit;
  logic [2:0] first_subblock_lut_code;
  logic [2:0] second_subblock_lut_code;

  logic valid_q;
  logic next_valid;
  ptbd_mode_t mode_q;
  ptbd_mode_t next_mode;
  ptbd_texel_t [15:0] texels_q;
  ptbd_texel_t [15:0] next_texels;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  assign solid_alpha_flag = word_i[PTBD_SOLID_BIT];
  assign split_orientation_bit = word_i[PTBD_SPLIT_BIT];
  assign first_subblock_lut_code = word_i[PTBD_LUT1_HI -: 3]; // see [R11]
  assign second_subblock_lut_code = word_i[PTBD_LUT2_HI -: 3];
  assign first_base.red = ptbd_widen_five_to_eight(word_i[PTBD_RED_HI -: 5]); // see [R9]
  assign first_base.green = ptbd_widen_five_to_eight(word_i[PTBD_GRN_HI -: 5]);
  assign first_base.blue = ptbd_widen_five_to_eight(word_i[PTBD_BLU_HI -: 5]);

  ptbd_mode_sel u_mode_sel (
    .word_i(word_i),
    .mode_o(sel_mode),
    .second_code_o(second_base)
  );

  // ----------------------------------------------------------------
  // Per-pixel decode; pixel p sits at column p/4, row p%4
  // ----------------------------------------------------------------
  for (genvar p = 0; p < PTBD_PIXELS; p++) begin : g_pix
    logic second_half;
    logic [1:0] index;
    localparam int COL = p / PTBD_SIDE;
    localparam int ROW = p % PTBD_SIDE;
    assign index = {word_i[PTBD_MSB_BASE + p], word_i[PTBD_LSB_BASE + p]}; // see [R15] see [R16]
    assign second_half = split_orientation_bit ? (ROW >= PTBD_HALF)
                                               : (COL >= PTBD_HALF); // see [R8]
    ptbd_texel u_texel (
      .base_i(second_half ? second_base : first_base),
      .lut_code_i(second_half ? second_subblock_lut_code
                              : first_subblock_lut_code), // see [R12] see [R13]
      .index_i(index),
      .solid_alpha_flag_i(solid_alpha_flag),
      .texel_o(calc[p])
    );
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  always_comb begin
    next_valid = valid_q;
    next_mode = mode_q;
    next_texels = texels_q;
    if (word_valid_i) begin
      next_valid = 1'b1; // see [R1]
      next_mode = sel_mode; // see [R22]
      next_texels = (sel_mode == PTBD_MODE_DIFF) ? calc : '0;
    end else begin
      next_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      valid_q <= 1'b0;
      mode_q <= PTBD_MODE_DIFF;
      texels_q <= '0;
    end else if (enable_i) begin
      valid_q <= next_valid;
      mode_q <= next_mode;
      texels_q <= next_texels;
    end
  end

  assign ready_o = enable_i;
  assign texels_valid_o = valid_q;
  assign mode_o = mode_q;
  assign diff_mode_o = (mode_q == PTBD_MODE_DIFF);
  assign texels_o = texels_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  chk_valid_follows: assert property (enable_i && word_valid_i |=> texels_valid_o) // see [R1]
    else $error("valid did not follow accepted word");
  chk_mode_t: assert property ( // see [R4]
    enable_i && word_valid_i && (word_i[63:56] == 8'hF9 || word_i[63:56] == 8'h07)
    |=> mode_o == PTBD_MODE_T)
    else $error("red overflow not flagged as T");
  chk_mode_diff: assert property ( // see [R7]
    enable_i && word_valid_i && word_i[58:56] == 3'h0 && word_i[50:48] == 3'h0
    && word_i[42:40] == 3'h0 |=> diff_mode_o)
    else $error("zero deltas not differential");
  chk_alpha_hole: assert property ( // see [R21]
    enable_i && word_valid_i && sel_mode == PTBD_MODE_DIFF && !word_i[33]
    && word_i[31] && !word_i[15] |=> texels_o[15] == '0)
    else $error("punch-through pixel not zero");
  chk_alpha_solid: assert property ( // see [R21]
    enable_i && word_valid_i && sel_mode == PTBD_MODE_DIFF && word_i[33]
    |=> texels_o[5].alpha == PTBD_ALPHA_ON)
    else $error("opaque pixel alpha not full");
  chk_clamp_top: assert property ( // see [R20]
    enable_i && word_valid_i && word_i[63:56] == 8'hF8 && word_i[39:37] == 3'h7
    && word_i[33] && !word_i[16] && word_i[0] && sel_mode == PTBD_MODE_DIFF
    |=> texels_o[0].red == 8'hFF)
    else $error("red not clamped high");
  chk_hold_frozen: assert property (!enable_i |=> $stable(texels_o) && $stable(mode_o))
    else $error("state moved while disabled");
  chk_mod_small: assert property ( // see [R18]
    enable_i && word_valid_i && sel_mode == PTBD_MODE_DIFF && !word_i[33]
    && !word_i[16] && !word_i[0] |=> texels_o[0].red == $past(first_base.red))
    else $error("zero modifier changed colour");
  chk_split_base: assert property ( // see [R8]
    enable_i && word_valid_i && sel_mode == PTBD_MODE_DIFF && !word_i[33]
    && !word_i[31] && !word_i[15] && !word_i[32]
    |=> texels_o[15].green == $past(second_base.green))
    else $error("right half not on second base");
  chk_split_rows: assert property ( // see [R8]
    enable_i && word_valid_i && sel_mode == PTBD_MODE_DIFF && !word_i[33]
    && word_i[32] && !word_i[18] && !word_i[2]
    |=> texels_o[2].red == $past(second_base.red))
    else $error("lower half not on second base");
  chk_first_widen: assert property ( // see [R9]
    enable_i && word_valid_i && sel_mode == PTBD_MODE_DIFF && !word_i[33]
    && !word_i[16] && !word_i[0]
    |=> texels_o[0].green == {$past(word_i[55:51]), $past(word_i[55:53])})
    else $error("first base not widened");
  chk_clamp_low: assert property ( // see [R20]
    enable_i && word_valid_i && word_i[63:56] == 8'h00 && word_i[39:37] == 3'h7
    && word_i[33] && word_i[16] && word_i[0] && sel_mode == PTBD_MODE_DIFF
    |=> texels_o[0].red == 8'h00)
    else $error("red not clamped low");
  chk_valid_drop: assert property (enable_i && !word_valid_i |=> !texels_valid_o) // see [R1]
    else $error("valid held without a word");
  chk_mode_h: assert property ( // see [R5]
    enable_i && word_valid_i && word_i[63:48] == 16'h0007 |=> mode_o == PTBD_MODE_H)
    else $error("green overflow not flagged as H");
  chk_mode_planar: assert property ( // see [R6]
    enable_i && word_valid_i && word_i[63:40] == 24'h0000F9 |=> mode_o == PTBD_MODE_PLANAR)
    else $error("blue overflow not flagged as planar");
  chk_other_zero: assert property ( // see [R22]
    enable_i && word_valid_i && sel_mode != PTBD_MODE_DIFF |=> texels_o == '0)
    else $error("non-differential block not zeroed");

  cov_diff: cover property (enable_i && word_valid_i && sel_mode == PTBD_MODE_DIFF);
  cov_t: cover property (enable_i && word_valid_i && sel_mode == PTBD_MODE_T);
  cov_h: cover property (enable_i && word_valid_i && sel_mode == PTBD_MODE_H);
  cov_planar: cover property (enable_i && word_valid_i && sel_mode == PTBD_MODE_PLANAR);
  cov_hole: cover property (
    enable_i && word_valid_i && sel_mode == PTBD_MODE_DIFF && !word_i[33]);

endmodule

// ==== verilog/ptbd_pkg.sv ====
package ptbd_pkg;

  // ----------------------------------------------------------------
  // Word fields
  // ----------------------------------------------------------------
  localparam int PTBD_RED_HI = 63;
  localparam int PTBD_RDELTA_HI = 58;
  localparam int PTBD_GRN_HI = 55;
  localparam int PTBD_GDELTA_HI = 50;
  localparam int PTBD_BLU_HI = 47;
  localparam int PTBD_BDELTA_HI = 42;
  localparam int PTBD_LUT1_HI = 39;
  localparam int PTBD_LUT2_HI = 36;
  localparam int PTBD_SOLID_BIT = 33;
  localparam int PTBD_SPLIT_BIT = 32;
  localparam int PTBD_MSB_BASE = 16;
  localparam int PTBD_LSB_BASE = 0;
  localparam int PTBD_PIXELS = 16;
  localparam int PTBD_SIDE = 4;
  localparam int PTBD_HALF = 2;

  // ----------------------------------------------------------------
  // Value limits
  // ----------------------------------------------------------------
  localparam logic signed [6:0] PTBD_CODE_MIN = 7'sh00;
  localparam logic signed [6:0] PTBD_CODE_MAX = 7'sh1F;
  localparam logic signed [9:0] PTBD_CH_MAX = 10'sh0FF;
  localparam logic [7:0] PTBD_ALPHA_ON = 8'hFF;
  localparam logic [7:0] PTBD_ZERO8 = 8'h00;
  localparam logic [1:0] PTBD_IDX_HOLE = 2'h2;

  // ----------------------------------------------------------------
  // Modifier magnitudes, small and large, per table code
  // ----------------------------------------------------------------
  localparam logic [7:0] PTBD_SMALL [8] = '{8'h02, 8'h05, 8'h09, 8'h0D,
                                             8'h12, 8'h18, 8'h21, 8'h2F};
  localparam logic [7:0] PTBD_LARGE [8] = '{8'h08, 8'h11, 8'h1D, 8'h2A,
                                             8'h3C, 8'h50, 8'h6A, 8'hB7};

  typedef enum logic [3:0] {
    PTBD_MODE_T = 4'h1,
    PTBD_MODE_H = 4'h2,
    PTBD_MODE_PLANAR = 4'h4,
    PTBD_MODE_DIFF = 4'h8
  } ptbd_mode_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] alpha;
  } ptbd_texel_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } ptbd_rgb_t;

  // Widen a five-bit code to eight bits by replicating its top bits
  function automatic logic [7:0] ptbd_widen_five_to_eight(input logic [4:0] c);
    return {c, c[4:2]};
  endfunction

endpackage

// ==== verilog/ptbd_mode_sel.sv ====
`timescale 1ns/10ps
module ptbd_mode_sel
  import ptbd_pkg::*;
(
  input wire logic [63:0] word_i,
  output ptbd_mode_t mode_o,
  output ptbd_rgb_t second_code_o
);

  logic signed [6:0] red_sum;
  logic signed [6:0] green_sum;
  logic signed [6:0] blue_sum;

  function automatic logic signed [6:0] code_sum(input logic [4:0] c, input logic [2:0] d);
    return $signed({2'h0, c}) + $signed({{4{d[2]}}, d});
  endfunction

  function automatic logic out_of_range(input logic signed [6:0] s);
    return (s < PTBD_CODE_MIN) || (s > PTBD_CODE_MAX);
  endfunction

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  always_comb begin
    red_sum = code_sum(word_i[PTBD_RED_HI -: 5], word_i[PTBD_RDELTA_HI -: 3]); // see [R2] see [R3]
    green_sum = code_sum(word_i[PTBD_GRN_HI -: 5], word_i[PTBD_GDELTA_HI -: 3]);
    blue_sum = code_sum(word_i[PTBD_BLU_HI -: 5], word_i[PTBD_BDELTA_HI -: 3]);
    if (out_of_range(red_sum)) begin
      mode_o = PTBD_MODE_T; // see [R4]
    end else if (out_of_range(green_sum)) begin
      mode_o = PTBD_MODE_H; // see [R5]
    end else if (out_of_range(blue_sum)) begin
      mode_o = PTBD_MODE_PLANAR; // see [R6]
    end else begin
      mode_o = PTBD_MODE_DIFF; // see [R7]
    end
    second_code_o.red = ptbd_widen_five_to_eight(red_sum[4:0]); // see [R10]
    second_code_o.green = ptbd_widen_five_to_eight(green_sum[4:0]);
    second_code_o.blue = ptbd_widen_five_to_eight(blue_sum[4:0]);
  end

endmodule

// ==== verilog/ptbd_texel.sv ====
`timescale 1ns/10ps
module ptbd_texel
  import ptbd_pkg::*;
(
  input ptbd_rgb_t base_i,
  input wire logic [2:0] lut_code_i,
  input wire logic [1:0] index_i,
  input wire logic solid_alpha_flag_i,
  output ptbd_texel_t texel_o
);

  logic signed [9:0] modifier;
  logic hole;

  function automatic logic [7:0] clamp_add(input logic [7:0] b, input logic signed [9:0] m);
    logic signed [9:0] s;
    s = $signed({2'h0, b}) + m;
    if (s < 0) begin
      return PTBD_ZERO8;
    end
    if (s > PTBD_CH_MAX) begin
      return PTBD_ALPHA_ON;
    end
    return s[7:0];
  endfunction

  // ----------------------------------------------------------------
  // Modifier pick and colour
  // ----------------------------------------------------------------
  always_comb begin
    hole = !solid_alpha_flag_i && (index_i == PTBD_IDX_HOLE);
    unique case (index_i)
      2'h3: modifier = -$signed({2'h0, PTBD_LARGE[lut_code_i]}); // see [R18]
      2'h1: modifier = $signed({2'h0, PTBD_LARGE[lut_code_i]});
      2'h2: modifier = solid_alpha_flag_i ? -$signed({2'h0, PTBD_SMALL[lut_code_i]})
                                          : 10'sh000; // see [R14] see [R17]
      2'h0: modifier = solid_alpha_flag_i ? $signed({2'h0, PTBD_SMALL[lut_code_i]})
                                          : 10'sh000;
    endcase
    if (hole) begin
      texel_o = '0; // see [R21]
    end else begin
      texel_o.red = clamp_add(base_i.red, modifier); // see [R19] see [R20]
      texel_o.green = clamp_add(base_i.green, modifier);
      texel_o.blue = clamp_add(base_i.blue, modifier);
      texel_o.alpha = PTBD_ALPHA_ON;
    end
  end

endmodule

// ==== test/ptbd_fetch_model.sv ====
`timescale 1ns/10ps
module ptbd_fetch_model (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic word_valid_o,
  output logic [63:0] word_o
);
  initial begin
    word_valid_o = 1'b0;
    word_o = 64'h0;
  end

  // ----------------------------------------------------------------
  // Present one block, lowest-address byte first
  // ----------------------------------------------------------------
  task automatic present(input logic [7:0] mem_bytes [8]);
    @(posedge clk_i);
    word_valid_o <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      word_o[63 - 8 * i -: 8] <= mem_bytes[i];
    end
  endtask

  // ----------------------------------------------------------------
  // Hold until taken, then release with a changed data pattern
  // ----------------------------------------------------------------
  task automatic release_bus(output logic late);
    int n;
    n = 0;
    @(posedge clk_i);
    while (ready_i !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    late = (ready_i !== 1'b1);
    word_valid_o <= 1'b0;
    word_o <= ~word_o;
  endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
module tb_top
  import ptbd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic enable = 1'b1;
  logic word_valid;
  logic [63:0] word;
  logic ready;
  logic texels_valid;
  ptbd_mode_t mode;
  logic diff_mode;
  ptbd_texel_t [15:0] texels;
  int bad_count = 0;
  int checked = 0;
  logic [63:0] w1 = 64'hE422_185E_F0F0_0FF0;
  logic [63:0] w2 = 64'hE422_185D_F0F0_0FF0;

  always #50 clk_sys = ~clk_sys;

  ptbd_fetch_model fetch_u (.clk_i(clk_sys), .ready_i(ready), .word_valid_o(word_valid),
    .word_o(word));

  ptbd_decoder dut_u (.clk_sys_i(clk_sys), .reset_i(reset), .enable_i(enable),
    .word_valid_i(word_valid), .word_i(word), .ready_o(ready), .texels_valid_o(texels_valid),
    .mode_o(mode), .diff_mode_o(diff_mode), .texels_o(texels));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic [3:0] exp_mode(input logic [63:0] w);
    int s [3];
    for (int i = 0; i < 3; i++) begin
      s[i] = int'(w[63 - 8 * i -: 5]) + int'($signed(w[58 - 8 * i -: 3]));
    end
    if (s[0] < 0 || s[0] > 31) return 4'h1;
    if (s[1] < 0 || s[1] > 31) return 4'h2;
    if (s[2] < 0 || s[2] > 31) return 4'h4;
    return 4'h8;
  endfunction

  function automatic logic [31:0] exp_texel(input logic [63:0] w, input int p);
    int sm [8] = '{2, 5, 9, 13, 18, 24, 33, 47};
    int lg [8] = '{8, 17, 29, 42, 60, 80, 106, 183};
    int m;
    int ch;
    logic sub2;
    logic [1:0] idx;
    logic [2:0] lut;
    logic [4:0] c5;
    logic [31:0] res;
    if (exp_mode(w) != 4'h8) return 32'h0;
    sub2 = w[32] ? (p % 4 >= 2) : (p / 4 >= 2);
    lut = sub2 ? w[36:34] : w[39:37];
    idx = {w[16 + p], w[p]};
    case (idx)
      2'h3: m = -lg[lut];
      2'h1: m = lg[lut];
      2'h2: m = w[33] ? -sm[lut] : 0;
      default: m = w[33] ? sm[lut] : 0;
    endcase
    if (!w[33] && idx == 2'h2) return 32'h0;
    for (int i = 0; i < 3; i++) begin
      c5 = 5'(int'(w[63 - 8 * i -: 5]) + (sub2 ? int'($signed(w[58 - 8 * i -: 3])) : 0));
      ch = int'({c5, c5[4:2]}) + m;
      if (ch < 0) ch = 0;
      if (ch > 255) ch = 255;
      res[31 - 8 * i -: 8] = 8'(ch);
    end
    res[7:0] = 8'hFF;
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [63:0] w);
    logic [7:0] b [8];
    for (int i = 0; i < 8; i++) begin
      b[i] = w[63 - 8 * i -: 8];
    end
    fetch_u.present(b);
  endtask

  task automatic take();
    logic late;
    fetch_u.release_bus(late);
    check("taken in time", {31'h0, late}, 32'h0);
  endtask

  task automatic check_out(input logic [63:0] w);
    check("texels_valid", {31'h0, texels_valid}, 32'h1);
    check("mode", {28'h0, mode}, {28'h0, exp_mode(w)});
    check("diff_mode", {31'h0, diff_mode}, {31'h0, exp_mode(w) == 4'h8});
    for (int p = 0; p < 16; p++) begin
      check("texel", texels[p], exp_texel(w, p));
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_modes();
    logic [63:0] ws [6] = '{64'h0700_0000_0000_0000, 64'hF900_0000_0000_0000,
      64'h0007_0000_0000_0000, 64'h0000_0700_0000_0000, 64'h0000_F900_0000_0000,
      64'hF800_0000_0000_0000};
    foreach (ws[i]) begin
      send(ws[i]);
      take();
      #1;
      check_out(ws[i]);
    end
    $display("test_modes done");
  endtask

  task automatic test_diff();
    send(w1);
    send(w2);
    #1;
    check_out(w1);
    take();
    #1;
    check_out(w2);
    @(posedge clk_sys);
    #1;
    check("valid drop", {31'h0, texels_valid}, 32'h0);
    check("texel hold", texels[13], exp_texel(w2, 13));
    $display("test_diff done");
  endtask

  task automatic test_luts();
    logic [63:0] w;
    logic [63:0] clamp_ws [2] = '{64'hF800_00E2_0000_0001, 64'h0000_00E2_0001_0001};
    for (int k = 0; k < 10; k++) begin
      w = {w1[63:40], 3'(k), 3'(7 - k), 2'(k), 32'h25C3_3C96};
      if (k >= 8) begin
        w = clamp_ws[k - 8];
      end
      send(w);
      take();
      #1;
      check_out(w);
    end
    $display("test_luts done");
  endtask

  task automatic test_freeze();
    send(w1);
    take();
    #1;
    check_out(w1);
    @(posedge clk_sys);
    enable <= 1'b0;
    send(64'h0700_0000_0000_0000);
    repeat (3) @(posedge clk_sys);
    #1;
    check("ready", {31'h0, ready}, 32'h0);
    check("frozen mode", {28'h0, mode}, 32'h8);
    check("frozen texel", texels[5], exp_texel(w1, 5));
    @(posedge clk_sys);
    enable <= 1'b1;
    @(posedge clk_sys);
    #1;
    check_out(64'h0700_0000_0000_0000);
    @(posedge clk_sys);
    reset <= 1'b1;
    #1;
    check("reset mode", {28'h0, mode}, 32'h8);
    check("reset valid", {31'h0, texels_valid}, 32'h0);
    take();
    @(posedge clk_sys);
    reset <= 1'b0;
    send(w1);
    take();
    #1;
    check_out(w1);
    $display("test_freeze done");
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    test_modes();
    test_diff();
    test_luts();
    test_freeze();
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
endmodule
